/* dv/pio_cell_bench.sv */
`timescale 1ns/1ps
`include "pio_params.svh"

module pio_cell_bench;
    localparam int DQ_W = `PIO_DQ_W;
    logic                      sys_clk;
    logic                      rst_b;
    logic                      lnk;
    pio_pkg::pio_cfg_s         cfg;
    pio_pkg::pio_ctl_s         la_ctl;
    logic [`PIO_IOCLK_N-1:0]   io_clk;
    logic [`PIO_IOCLK_N-1:0]   clk_on;
    logic [`PIO_BLK_N-1:0]     io_bclk;
    logic [`PIO_BLK_N-1:0]     bclk_on;
    logic [`PIO_BLK_N-1:0]     io_boe;
    logic [`PIO_BLK_N-1:0]     io_bce;
    logic [`PIO_BLK_N-1:0]     io_bclr;
    logic [DQ_W-1:0]           pin_dq_i;
    logic                      pin_dqs_i;
    logic [DQ_W-1:0]           pin_dq_o;
    logic                      pin_dq_oe;
    logic [DQ_W-1:0]           io_fwd;
    logic [DQ_W-1:0]           tx_rise;
    logic [DQ_W-1:0]           tx_fall;
    logic                      tx_take;
    logic                      rx_valid;
    logic                      rx_ready;
    logic [2*DQ_W-1:0]         rx_data;
    logic                      rx_drop;
    logic [2*DQ_W-1:0]         exp_q[$];
    int                        n_fail;
    int                        checked;
    int                        n_drop = 0;
    int                        n_side = 0;
    logic                      la_oe;
    logic                      la_ce;
    logic                      side_drop;

    // system clock 100 ns; link clock 800 ns at an unrelated phase
    initial sys_clk = 1'b0;
    always #50 sys_clk = ~sys_clk;
    initial begin
        lnk = 1'b0;
        #37;
        forever #400 lnk = ~lnk;
    end

    // link clocks reach the cell on the falling system edge only
    always @(negedge sys_clk) begin
        io_clk     <= lnk ? clk_on : '0;
        io_bclk    <= lnk ? bclk_on : '0;
        la_ctl     <= '{oe: la_oe, ce: la_ce, clk: lnk, clr: 1'b0};
    end

    // count dropped capture edges of both cells where the pulses are settled
    always @(negedge sys_clk) begin
        if (rx_drop === 1'b1) n_drop <= n_drop + 1;
        if (side_drop === 1'b1) n_side <= n_side + 1;
    end

    pio_cell u_pio_cell (
        .sys_clk(sys_clk), .rst_b(rst_b), .cfg(cfg), .io_clk(io_clk), .io_bclk(io_bclk),
        .io_boe(io_boe), .io_bce(io_bce), .io_bclr(io_bclr), .la_ctl(la_ctl),
        .pin_dq_i(pin_dq_i), .pin_dqs_i(pin_dqs_i), .pin_dq_o(pin_dq_o),
        .pin_dq_oe(pin_dq_oe), .io_fwd(io_fwd), .tx_rise(tx_rise), .tx_fall(tx_fall),
        .tx_take(tx_take), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
        .rx_drop(rx_drop)
    );

    pio_mem_model #(.DQ_W(DQ_W)) u_pio_mem_model (.dq(pin_dq_i), .dqs(pin_dqs_i));

    // side bank cell: captures on the launch clock, its stream is never taken
    pio_cell #(.TOP_BANK(1'b0)) u_pio_cell_side (
        .sys_clk(sys_clk), .rst_b(rst_b), .cfg(cfg), .io_clk(io_clk), .io_bclk(io_bclk),
        .io_boe(io_boe), .io_bce(io_bce), .io_bclr(io_bclr), .la_ctl(la_ctl),
        .pin_dq_i(pin_dq_i), .pin_dqs_i(pin_dqs_i), .pin_dq_o(), .pin_dq_oe(), .io_fwd(),
        .tx_rise(tx_rise), .tx_fall(tx_fall), .tx_take(), .rx_valid(), .rx_ready(1'b0),
        .rx_data(), .rx_drop(side_drop)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t ns got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc

    // partner sends n pairs; the first keep pairs are expected back in order
    task automatic burst(input int n, input int keep, input logic [DQ_W-1:0] base);
        logic [DQ_W-1:0]   r;
        logic [2*DQ_W-1:0] w;
        for (int i = 0; i < n; i++) begin
            r = base + DQ_W'(i * 9);
            w = {r, r ^ 8'hC3};
            if (cfg.inv.dq_in) w = ~w;
            if (i < keep) exp_q.push_back(w);
            u_pio_mem_model.send(r, r ^ 8'hC3);
        end
    endtask : burst

    // take n words back to back, then the stream must be empty
    task automatic drain(input int n);
        int got;
        got = 0;
        @(negedge sys_clk);
        rx_ready = 1'b1;
        for (int i = 0; i < 400 && got < n; i++) begin
            if (rx_valid === 1'b1) begin
                check(rx_data, exp_q.pop_front());
                got++;
            end
            @(negedge sys_clk);
        end
        rx_ready = 1'b0;
        check(rx_valid, 1'b0);
        if (got != n) begin
            n_fail++;
            end_of_test();
        end
    endtask : drain

    // double rate capture, optionally inverted, and forwarding of pin data
    task automatic t_capture(input logic inv);
        @(negedge sys_clk);
        cfg.inv.dq_in = inv;
        cfg.ddr = 1'b1;
        burst(3, 3, 8'h11);
        drain(3);
        cyc(4);
        check(io_fwd ^ {DQ_W{inv}}, pin_dq_i);
    endtask : t_capture

    // 16 buffered words plus the output stage, then capture is skipped
    task automatic t_fill();
        int d0;
        @(negedge sys_clk);
        d0 = n_drop;
        cfg.ddr = 1'b1;
        cfg.inv.dq_in = 1'b0;
        burst(18, 17, 8'h40);
        cyc(4);
        check(n_drop - d0, 1);
        drain(17);
    endtask : t_fill

    // launch: pin shows rise word while clock high, fall word while low in double rate; inverted rise word only in single rate
    task automatic t_out(input logic ddr);
        int n_r;
        int n_f;
        int s0;
        n_r = 0;
        n_f = 0;
        @(negedge sys_clk);
        cfg.ddr = ddr;
        cfg.inv.tx = !ddr;
        tx_rise = 8'hA5;
        tx_fall = 8'h3C;
        cyc(16);
        s0 = n_side;
        repeat (32) begin
            @(negedge sys_clk);
            if (pin_dq_o === (ddr ? 8'hA5 : 8'h5A)) n_r++;
            if (pin_dq_o === 8'h3C) n_f++;
        end
        check(n_r, ddr ? 16 : 32);
        check(n_f, ddr ? 16 : 0);
        check(n_side - s0, 4);
        cfg.inv.tx = 1'b0;
    endtask : t_out

    // each clock source selectable; constant source and ce low give no launch
    task automatic t_sel();
        int n;
        for (int s = 0; s < 14; s++) begin
            @(negedge sys_clk);
            cfg.clk_sel = (s == 13) ? 4'h0 : 4'(s);
            clk_on = (s < 8) ? 8'(1 << s) : ((s == 13) ? 8'h01 : 8'h00);
            bclk_on = (s >= 8 && s < 12) ? 4'(1 << (s - 8)) : 4'h0;
            io_bce = (s == 13) ? 4'h0 : 4'hF;
            cyc(8);
            n = 0;
            repeat (24) begin
                @(negedge sys_clk);
                if (tx_take === 1'b1) n++;
            end
            check(n, (s < 12) ? 3 : 0);
        end
        cfg.clk_sel = 4'h0;
        clk_on = 8'h01;
        bclk_on = 4'h0;
        io_bce = 4'hF;
    endtask : t_sel

    // wait at most 20 cycles for launch clock 0 to show a level
    task automatic wait_lnk(input logic lvl);
        int i;
        i = 0;
        while (i < 20 && io_clk[0] !== lvl) begin
            @(negedge sys_clk);
            i++;
        end
        if (io_clk[0] !== lvl) begin
            n_fail++;
            end_of_test();
        end
    endtask : wait_lnk

    // registered enable from the rise register or the falling edge register
    task automatic t_oe(input int sel, input logic neg, input logic inv);
        @(negedge sys_clk);
        cfg.ctl_sel = 2'(sel);
        cfg.oe_neg = neg;
        wait_lnk(1'b1);
        wait_lnk(1'b0);
        cfg.inv.oe = inv;
        io_boe = inv ? 4'h0 : 4'(1 << sel);
        wait_lnk(1'b1);
        cyc(5);
        check(pin_dq_oe, !neg);
        cyc(6);
        check(pin_dq_oe, 1'b1);
        io_bclr = 4'(1 << sel);
        cyc(12);
        check(pin_dq_oe, 1'b0);
        io_boe = 4'h0;
        cfg.inv.oe = 1'b0;
        cyc(2);
        io_bclr = 4'h0;
        cyc(12);
        check(pin_dq_oe, 1'b0);
    endtask : t_oe

    // controls taken straight from core routing
    task automatic t_direct();
        @(negedge sys_clk);
        cfg.ctl_sel = 2'h0;
        cfg.oe_neg = 1'b0;
        cfg.direct = 1'b1;
        la_oe = 1'b1;
        la_ce = 1'b1;
        cyc(16);
        check(pin_dq_oe, 1'b1);
        la_oe = 1'b0;
        cyc(16);
        check(pin_dq_oe, 1'b0);
    endtask : t_direct

    // reset, then the scenarios in turn
    initial begin
        n_fail = 0;
        checked = 0;
        rst_b = 1'b0;
        cfg = '0;
        la_oe = 1'b0;
        la_ce = 1'b0;
        clk_on = 8'h01;
        bclk_on = '0;
        io_boe = '0;
        io_bce = 4'hF;
        io_bclr = '0;
        tx_rise = '0;
        tx_fall = '0;
        rx_ready = 1'b0;
        repeat (20) @(negedge sys_clk);
        check({pin_dq_o, pin_dq_oe, tx_take, rx_valid, rx_drop, rx_data}, '0);
        rst_b = 1'b1;
        cyc(4);
        t_capture(1'b0);
        t_capture(1'b1);
        t_fill();
        t_out(1'b1);
        t_out(1'b0);
        t_sel();
        for (int i = 0; i < 4; i++) t_oe(i, i[0], i[1]);
        t_direct();
        end_of_test();
    end
endmodule : pio_cell_bench

/* dv/pio_mem_model.sv */
`timescale 1ns/1ps

// far-side memory: drives strobe-framed double rate words onto the cell's pins
module pio_mem_model #(
    parameter int DQ_W = 8
) (
    output logic [DQ_W-1:0] dq,
    output logic            dqs
);
    // strobe stands still low between frames
    initial begin
        dq  = '0;
        dqs = 1'b0;
    end

    // one 800 ns strobe period per pair, rise data centred on its edge, fall data 200 ns before and 100 ns after its edge
    task automatic send(input logic [DQ_W-1:0] w_rise, input logic [DQ_W-1:0] w_fall);
        dq = w_rise;
        #200;
        dqs = 1'b1;
        #200;
        dq = w_fall;
        #200;
        dqs = 1'b0;
        #100;
        dq = ~w_fall; // released bus shows the inverse of the last value
        #100;
    endtask : send
endmodule : pio_mem_model

/* src/pio_cell.sv */
// Function
// - cell has two input regs, a latch, two output regs, two enable regs
// - double rate input samples both edges, both samples go to core
// - double rate output drives one bit per link clock edge
// - pin enable comes from a registered enable inside the cell
// - one enable register loads on the falling link clock edge
// - block gets four enables, clock enables, clocks, clears; cell selects
// - eight dedicated io clocks are selectable clock sources
// - pin input data is forwarded to the interconnect
// - controls may come directly from core routing instead
// - every input to the cell has selectable inversion
// - strobe based capture exists only in top or bottom banks
// - side banks ignore the read strobe and capture on the clock
// - strobe group width is eight, sixteen or thirty-two bits
// - memory clock stays at or below the 200 MHz ceiling
`timescale 1ns/1ps
`include "pio_params.svh"

module pio_fifo #(
    parameter int W = 16,
    parameter int D = `PIO_FIFO_D
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);
    localparam logic [AW-1:0] LAST = AW'(D - 1);
    localparam logic [CW-1:0] FULL = CW'(D);

    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    logic          push;
    logic          pop;

    // honest full and empty from the word count
    assign in_ready  = (cnt_q != FULL);
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_q];

    // storage
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + CW'(push) - CW'(pop);
        end
    end
endmodule : pio_fifo

module pio_cell #(
    parameter int   DQ_W     = `PIO_DQ_W,
    parameter int   FIFO_D   = `PIO_FIFO_D,
    parameter logic TOP_BANK = `PIO_TOP_BANK
) (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_b,
    input  wire pio_pkg::pio_cfg_s        cfg,
    input  wire logic [`PIO_IOCLK_N-1:0]  io_clk,
    input  wire logic [`PIO_BLK_N-1:0]    io_bclk,
    input  wire logic [`PIO_BLK_N-1:0]    io_boe,
    input  wire logic [`PIO_BLK_N-1:0]    io_bce,
    input  wire logic [`PIO_BLK_N-1:0]    io_bclr,
    input  wire pio_pkg::pio_ctl_s        la_ctl,
    input  wire logic [DQ_W-1:0]          pin_dq_i,
    input  wire logic                     pin_dqs_i,
    output logic [DQ_W-1:0]               pin_dq_o,
    output logic                          pin_dq_oe,
    output logic [DQ_W-1:0]               io_fwd,
    input  wire logic [DQ_W-1:0]          tx_rise,
    input  wire logic [DQ_W-1:0]          tx_fall,
    output logic                          tx_take,
    output logic                          rx_valid,
    input  wire logic                     rx_ready,
    output logic [2*DQ_W-1:0]             rx_data,
    output logic                          rx_drop
);
    localparam int  IN_W = DQ_W + 1 + `PIO_IOCLK_N + 4 * `PIO_BLK_N;
    localparam int  MIN_CYC = `PIO_MEM_MIN_CYC;
    localparam logic W_OK = (DQ_W == 8) || (DQ_W == 16) || (DQ_W == 32);

    // pick one of the four block lines
    function automatic logic sel4(input logic [3:0] v, input logic [1:0] i);
        sel4 = v[i];
    endfunction : sel4

    logic [IN_W-1:0]          m1_q;
    logic [IN_W-1:0]          s_q;
    logic [DQ_W-1:0]          dq_s;
    logic                     dqs_s;
    logic [`PIO_IOCLK_N-1:0]  ck_s;
    logic [`PIO_BLK_N-1:0]    bck_s;
    logic [`PIO_BLK_N-1:0]    boe_s;
    logic [`PIO_BLK_N-1:0]    bce_s;
    logic [`PIO_BLK_N-1:0]    bclr_s;
    logic [`PIO_CLK_SRC_N-1:0] src;
    pio_pkg::pio_ctl_s        ctl;
    logic [DQ_W-1:0]          dq_in;
    logic                     cap_clk;
    logic                     lclk_q;
    logic                     cclk_q;
    logic                     l_rise;
    logic                     l_fall;
    logic                     c_rise;
    logic                     c_fall;
    logic                     room;
    logic                     cap_en;
    logic [DQ_W-1:0]          in_rise_q;
    logic [DQ_W-1:0]          in_fall_q;
    logic [DQ_W-1:0]          lat_q;
    logic                     push_q;
    logic [2*DQ_W-1:0]        push_data;
    logic [DQ_W-1:0]          out_rise_q;
    logic [DQ_W-1:0]          out_fall_q;
    logic                     oe_pos_q;
    logic                     oe_neg_q;
    logic                     f_valid;
    logic                     f_ready;
    logic [2*DQ_W-1:0]        f_data;

    // two-stage synchroniser for every input from outside the domain
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            m1_q <= '0;
            s_q  <= '0;
        end else begin
            m1_q <= {pin_dq_i, pin_dqs_i, io_clk, io_bclk, io_boe, io_bce, io_bclr};
            s_q  <= m1_q;
        end
    end

    assign {dq_s, dqs_s, ck_s, bck_s, boe_s, bce_s, bclr_s} = s_q;
    assign src = {bck_s, ck_s};

    // control select: block lines or core routing, then inversion
    always_comb begin
        if (cfg.direct) begin
            ctl = la_ctl;
        end else begin
            ctl.oe  = sel4(boe_s, cfg.ctl_sel);
            ctl.ce  = sel4(bce_s, cfg.ctl_sel);
            ctl.clr = sel4(bclr_s, cfg.ctl_sel);
            ctl.clk = (cfg.clk_sel < 4'(`PIO_CLK_SRC_N)) ? src[cfg.clk_sel] : 1'b0;
        end
        ctl.oe  = ctl.oe ^ cfg.inv.oe;
        ctl.ce  = ctl.ce ^ cfg.inv.ce;
        ctl.clr = ctl.clr ^ cfg.inv.clr;
        ctl.clk = ctl.clk ^ cfg.inv.clk;
    end

    assign dq_in = dq_s ^ {DQ_W{cfg.inv.dq_in}};
    // strobe capture only where the bank has it, else the launch clock
    assign cap_clk = TOP_BANK ? (dqs_s ^ cfg.inv.dqs) : ctl.clk;

    // edge finding on the sampled link clocks
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            lclk_q <= 1'b0;
            cclk_q <= 1'b0;
        end else begin
            lclk_q <= ctl.clk;
            cclk_q <= cap_clk;
        end
    end

    assign l_rise = ctl.clk && !lclk_q;
    assign l_fall = !ctl.clk && lclk_q;
    assign c_rise = cap_clk && !cclk_q;
    assign c_fall = !cap_clk && cclk_q;
    // a full buffer stalls capture
    assign room   = f_ready && !push_q;
    assign cap_en = ctl.ce && room;

    // input registers and latch; rise sample retimed at the fall
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            in_rise_q <= '0;
            in_fall_q <= '0;
            lat_q     <= '0;
            push_q    <= 1'b0;
        end else if (ctl.clr) begin
            in_rise_q <= '0;
            in_fall_q <= '0;
            lat_q     <= '0;
            push_q    <= 1'b0;
        end else begin
            push_q <= 1'b0;
            if (c_rise && cap_en) begin
                in_rise_q <= dq_in;
                push_q    <= !cfg.ddr;
            end
            if (c_fall && cap_en && cfg.ddr) begin
                in_fall_q <= dq_in;
                lat_q     <= in_rise_q;
                push_q    <= 1'b1;
            end
        end
    end

    assign push_data = cfg.ddr ? {lat_q, in_fall_q} : {in_rise_q, {DQ_W{1'b0}}};

    // lost sample flag when the buffer is full at a capture edge
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_drop <= 1'b0;
        end else begin
            rx_drop <= ctl.ce && !ctl.clr && !room && (cfg.ddr ? c_fall : c_rise);
        end
    end

    pio_fifo #(
        .W (2 * DQ_W),
        .D (FIFO_D)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .in_valid  (push_q),
        .in_ready  (f_ready),
        .in_data   (push_data),
        .out_valid (f_valid),
        .out_ready (!rx_valid || rx_ready),
        .out_data  (f_data)
    );

    // registered core-side output stage
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_valid <= 1'b0;
            rx_data  <= '0;
        end else if (!rx_valid || rx_ready) begin
            rx_valid <= f_valid;
            if (f_valid) begin
                rx_data <= f_data;
            end
        end
    end

    // pin data forwarded to the interconnect
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            io_fwd <= '0;
        end else begin
            io_fwd <= dq_in;
        end
    end

    // output and enable registers; negative-edge enable follows the fall
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            out_rise_q <= '0;
            out_fall_q <= '0;
            oe_pos_q   <= 1'b0;
            oe_neg_q   <= 1'b0;
            tx_take    <= 1'b0;
        end else if (ctl.clr) begin
            out_rise_q <= '0;
            out_fall_q <= '0;
            oe_pos_q   <= 1'b0;
            oe_neg_q   <= 1'b0;
            tx_take    <= 1'b0;
        end else begin
            tx_take <= l_rise && ctl.ce;
            if (l_rise && ctl.ce) begin
                out_rise_q <= tx_rise ^ {DQ_W{cfg.inv.tx}};
                out_fall_q <= (cfg.ddr ? tx_fall : tx_rise) ^ {DQ_W{cfg.inv.tx}};
                oe_pos_q   <= ctl.oe;
            end
            if (l_fall && ctl.ce) begin
                oe_neg_q <= oe_pos_q;
            end
        end
    end

    // pin drive: rise register while clock high, fall register while low in double rate mode, else rise register
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_dq_o  <= '0;
            pin_dq_oe <= 1'b0;
        end else begin
            pin_dq_o  <= (cfg.ddr && !lclk_q) ? out_fall_q : out_rise_q;
            pin_dq_oe <= cfg.oe_neg ? oe_neg_q : oe_pos_q;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    property p_width;
        W_OK;
    endproperty
    a_width: assert property (p_width)
        else $error("group width not 8, 16 or 32");

    property p_ddr_cap;
        c_fall && cap_en && cfg.ddr && !ctl.clr |=>
            push_q && (lat_q == $past(in_rise_q)) && (in_fall_q == $past(dq_in));
    endproperty
    a_ddr_cap: assert property (p_ddr_cap)
        else $error("double rate capture lost a sample");

    property p_push_room;
        push_q |-> f_ready;
    endproperty
    a_push_room: assert property (p_push_room)
        else $error("push into full buffer");

    property p_fall_out;
        cfg.ddr && !lclk_q && $stable(cfg) |=> pin_dq_o == $past(out_fall_q);
    endproperty
    a_fall_out: assert property (p_fall_out)
        else $error("low clock phase not driving fall register");

    property p_rise_out;
        l_rise && ctl.ce && !ctl.clr ##1 $stable(cfg) |=>
            pin_dq_o == ($past(tx_rise, 2) ^ {DQ_W{$past(cfg.inv.tx, 2)}});
    endproperty
    a_rise_out: assert property (p_rise_out)
        else $error("rise data not on pin after rising edge");

    property p_oe_reg;
        l_rise && ctl.ce && !ctl.clr && !cfg.oe_neg ##1 $stable(cfg) |=>
            pin_dq_oe == $past(ctl.oe, 2);
    endproperty
    a_oe_reg: assert property (p_oe_reg)
        else $error("pin enable not from enable register");

    property p_oe_neg;
        l_fall && ctl.ce && !ctl.clr |=> oe_neg_q == $past(oe_pos_q);
    endproperty
    a_oe_neg: assert property (p_oe_neg)
        else $error("falling edge enable register not loaded");

    property p_clr;
        ctl.clr |=> (in_rise_q == '0) && (out_rise_q == '0) && !oe_pos_q && !push_q;
    endproperty
    a_clr: assert property (p_clr)
        else $error("selected clear did not clear cell");

    property p_fwd;
        ##2 io_fwd == ($past(pin_dq_i, 3) ^ {DQ_W{$past(cfg.inv.dq_in)}});
    endproperty
    a_fwd: assert property (p_fwd)
        else $error("forwarded data wrong");

    property p_side_bank;
        !TOP_BANK |-> (c_rise == l_rise);
    endproperty
    a_side_bank: assert property (p_side_bank)
        else $error("side bank capture used the strobe");

    property p_edge_gap;
        c_rise |-> ##MIN_CYC !c_rise;
    endproperty
    a_edge_gap: assert property (p_edge_gap)
        else $error("capture edges closer than the rate ceiling");
endmodule : pio_cell

/* src/pio_params.svh */
`ifndef PIO_PARAMS_SVH
`define PIO_PARAMS_SVH
// data lines per strobe group: 8, 16 or 32
`define PIO_DQ_W 8
`define PIO_FIFO_D 16
// dedicated row or column clocks and per-block control lines
`define PIO_IOCLK_N 8
`define PIO_BLK_N 4
`define PIO_CLK_SRC_N 12
// bank group strap: 1 for top or bottom banks with strobe support
`define PIO_TOP_BANK 1'b1
// memory clock ceiling and system clock period
`define PIO_MEM_MAX_MHZ 200
`define PIO_MEM_MIN_PER_PS (1000000 / `PIO_MEM_MAX_MHZ)
`define PIO_SYS_PER_PS 100000
`define PIO_MEM_MIN_CYC ((`PIO_MEM_MIN_PER_PS + `PIO_SYS_PER_PS - 1) / `PIO_SYS_PER_PS)
`endif

/* src/pio_pkg.sv */
package pio_pkg;
    // one set of block control lines
    typedef struct packed {
        logic oe;
        logic ce;
        logic clk;
        logic clr;
    } pio_ctl_s;

    // per-input inversion selects
    typedef struct packed {
        logic dq_in;
        logic dqs;
        logic tx;
        logic oe;
        logic ce;
        logic clk;
        logic clr;
    } pio_inv_s;

    // static cell configuration
    typedef struct packed {
        logic     ddr;
        logic     direct;
        logic     oe_neg;
        logic [3:0] clk_sel;
        logic [1:0] ctl_sel;
        pio_inv_s inv;
    } pio_cfg_s;
endpackage : pio_pkg
